// file: mode_ctrl_pkg.sv
// Package for the hardware mode control block: offsets, fields, resets, timing.
// Assumes a 32-bit AHB-Lite register bus and a single 125 MHz clock.
package mode_ctrl_pkg;
   // Byte addresses of the registers
   localparam logic [11:0] HW_MODE_OFFSET   = 12'h300;
   localparam logic [11:0] IRQ_STATUS_OFFSET = 12'h340;
   localparam logic [11:0] IRQ_MASK_OFFSET  = 12'h344;
   localparam logic [11:0] EVENT_OFFSET     = 12'h348;
   // Field positions of the mode register
   localparam int XCVR_RESET_BIT  = 31;
   localparam int OC_SELECT_BIT   = 15;
   localparam int BUS_WIDTH_BIT   = 8;
   localparam int DMA_ACK_POLARITY_BIT    = 6;
   localparam int DMA_REQUEST_POLARITY_BIT    = 5;
   localparam int IRQ_POL_BIT     = 2;
   localparam int IRQ_TRIG_BIT    = 1;
   localparam int IRQ_MASTER_BIT  = 0;
   // Writable bits; reserved positions stay zero
   localparam logic [31:0] HW_MODE_WMASK = 32'h8000_8167;
   localparam logic [31:0] HW_MODE_RESET = 32'h0000_0100;
   // Event layout of status and mask
   localparam int NUM_EVENTS = 4;
   localparam logic [3:0] EVENT_RESET = 4'h0;
   // Edge mode pulse width
   localparam int PULSE_NS = 64;
   localparam int CLOCK_NS = 8;
   localparam int PULSE_CYCLES = (PULSE_NS + CLOCK_NS - 1) / CLOCK_NS;
   localparam logic [1:0] HRESP_OKAY = 2'b00;
   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
endpackage

// file: irq_pulse_shaper.sv
// Turns an interrupt request level into the output waveform: level or timed pulse.
// Assumes all inputs are on the same clock as the shaper.
module irq_pulse_shaper
   import mode_ctrl_pkg::*;
#(
   parameter int WIDTH = PULSE_CYCLES
) (
   // Clock and reset
   input  wire logic clock,
   input  wire logic srst,
   // Control
   input  wire logic request,
   input  wire logic edge_mode,
   input  wire logic active_high,
   // Output
   output logic      irq_pin_r
);
   logic [7:0] count_r;
   logic [7:0] count_nxt;
   logic       req_d_r;
   logic       asserted;
   logic       pin_nxt;

   // Pulse counter restarts on each rising request
   always_comb begin
      count_nxt = count_r;
      if (!edge_mode || !request) begin
         count_nxt = 8'h00;
      end else if (request && !req_d_r) begin
         count_nxt = 8'(WIDTH); // R10
      end else if (count_r != 8'h00) begin
         count_nxt = count_r - 8'h01;
      end
      asserted = edge_mode ? (count_nxt != 8'h00) : request;
      pin_nxt  = active_high ? asserted : !asserted; // R7
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         count_r   <= 8'h00;
         req_d_r   <= 1'b0;
         irq_pin_r <= !HW_MODE_RESET[IRQ_POL_BIT]; // Rests inactive so reset never signals
      end else begin
         count_r   <= count_nxt;
         req_d_r   <= request;
         irq_pin_r <= pin_nxt;
      end
   end

   // Edge mode pulse lasts exactly WIDTH cycles
   sequence rise_s;
      edge_mode && request && !req_d_r && active_high;
   endsequence
   property pulse_width_p;
      @(posedge clock) disable iff (srst)
         (rise_s ##0 (edge_mode && request && active_high)[*1]) |=> irq_pin_r;
   endproperty
   AST_PULSE_START: assert property (pulse_width_p) else $error("edge pulse did not start"); // R10
   AST_PULSE_END: assert property (@(posedge clock) disable iff (srst) // R10
      (edge_mode && active_high && count_r == 8'h01 && request && req_d_r) |=> !irq_pin_r)
      else $error("edge pulse too long");
endmodule

// file: hardware_mode_control_register.sv
// Hardware mode control register with AHB-Lite slave, interrupt gating and pin polarity.
// Assumes one clock domain; event inputs are pulses from logic on this clock.
// Operation
// R1 - Bit 31 set to one holds every transceiver in reset until software writes it back to zero.
// R2 - Software writes zero to reserved bits 30..16 and 14..9, and they read back zero here.
// R3 - Bit 15 chooses digital (0) or analog (1) overcurrent detection on the three port inputs.
// R4 - Bit 8 selects a 16-bit (0) or 32-bit (1) host data bus and resets to one.
// R5 - Bit 6 makes the DMA acknowledge input active high when one, active low when zero.
// R6 - Bit 5 makes the DMA request output active high when one, active low when zero.
// R7 - Bit 1 chooses level (0) or edge pulse (1) interrupts and bit 2 chooses low or high active.
// R8 - With the master enable at zero the interrupt output is never asserted.
// R9 - With the master enable at one the interrupt follows the enabled, pending events.
// R10 - An edge-mode interrupt pulse lasts a fixed configurable number of clock cycles.
module hardware_mode_control_register
   import mode_ctrl_pkg::*;
#(
   parameter int PULSE_WIDTH = PULSE_CYCLES
) (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        srst,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [11:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic      [1:0]  hresp,
   // Block events and DMA
   input  wire logic [3:0]  event_in,
   input  wire logic        dma_request_internal,
   input  wire logic        dma_ack_input,
   // Overcurrent pins, active low
   input  wire logic        overcurrent_input_port1_n,
   input  wire logic        overcurrent_input_port2_n,
   input  wire logic        overcurrent_input_port3_n,
   // Outputs to the rest of the chip and pins
   output logic             transceiver_reset_all,
   output logic             overcurrent_sense_select,
   output logic             bus_width_32,
   output logic             dma_request_output,
   output logic             dma_ack_active,
   output logic      [2:0]  overcurrent_flag,
   output logic             irq_out
);
   logic [31:0] mode_r;
   logic [31:0] mode_nxt;
   logic [3:0]  status_r;
   logic [3:0]  status_nxt;
   logic [3:0]  mask_r;
   logic [3:0]  mask_nxt;
   logic        wr_pend_r;
   logic        wr_pend_nxt;
   logic [11:0] addr_r;
   logic [11:0] addr_nxt;
   logic [31:0] rdata_nxt;
   logic [2:0]  oc_meta_r;
   logic [2:0]  oc_sync_r;
   logic        ack_meta_r;
   logic        ack_sync_r;
   logic        xrst_r;
   logic        ocsel_r;
   logic        bw_r;
   logic        dma_request_output_r;
   logic        ack_r;
   logic [2:0]  ocf_r;
   logic        irq_request;
   logic        addr_phase;

   assign addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ);

   // Address phase capture; writes land one cycle later with hwdata
   always_comb begin
      wr_pend_nxt = addr_phase && hwrite;
      addr_nxt    = addr_phase ? haddr : addr_r;
      rdata_nxt   = 32'h0000_0000;
      if (addr_phase && !hwrite) begin
         unique case (haddr)
            HW_MODE_OFFSET:    rdata_nxt = mode_r;
            IRQ_STATUS_OFFSET: rdata_nxt = {28'h000_0000, status_r};
            IRQ_MASK_OFFSET:   rdata_nxt = {28'h000_0000, mask_r};
            EVENT_OFFSET:      rdata_nxt = {28'h000_0000, event_in};
            default:           rdata_nxt = 32'h0000_0000; // Unmapped reads zero
         endcase
      end
   end

   // Register writes and sticky event flags
   always_comb begin
      mode_nxt   = mode_r;
      mask_nxt   = mask_r;
      status_nxt = status_r;
      if (wr_pend_r && addr_r == HW_MODE_OFFSET) begin
         mode_nxt = hwdata & HW_MODE_WMASK; // R1 R2 R3 R4
      end
      if (wr_pend_r && addr_r == IRQ_MASK_OFFSET) begin
         mask_nxt = hwdata[3:0];
      end
      if (wr_pend_r && addr_r == IRQ_STATUS_OFFSET) begin
         status_nxt = status_r & ~hwdata[3:0];
      end
      status_nxt = status_nxt | event_in; // Set wins over a same-cycle clear
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         mode_r    <= HW_MODE_RESET; // R4
         mask_r    <= EVENT_RESET;
         status_r  <= EVENT_RESET;
         wr_pend_r <= 1'b0;
         addr_r    <= 12'h000;
         hrdata    <= 32'h0000_0000;
      end else begin
         mode_r    <= mode_nxt;
         mask_r    <= mask_nxt;
         status_r  <= status_nxt;
         wr_pend_r <= wr_pend_nxt;
         addr_r    <= addr_nxt;
         hrdata    <= rdata_nxt;
      end
   end

   // Zero wait states; the slave never stalls or errors
   always_ff @(posedge clock) begin
      if (srst) begin
         hreadyout <= 1'b1;
         hresp     <= HRESP_OKAY;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= HRESP_OKAY;
      end
   end

   // Pin synchronisers; first stage feeds only the second
   always_ff @(posedge clock) begin
      if (srst) begin
         oc_meta_r  <= 3'h7;
         oc_sync_r  <= 3'h7;
         ack_meta_r <= 1'b0;
         ack_sync_r <= 1'b0;
      end else begin
         oc_meta_r  <= {overcurrent_input_port3_n, overcurrent_input_port2_n, overcurrent_input_port1_n};
         oc_sync_r  <= oc_meta_r;
         ack_meta_r <= dma_ack_input;
         ack_sync_r <= ack_meta_r;
      end
   end

   // Mode-driven outputs, all registered
   always_ff @(posedge clock) begin
      if (srst) begin
         xrst_r  <= 1'b0;
         ocsel_r <= 1'b0;
         bw_r    <= 1'b1;
         dma_request_output_r  <= 1'b0;
         ack_r   <= 1'b0;
         ocf_r   <= 3'h0;
      end else begin
         xrst_r  <= mode_r[XCVR_RESET_BIT]; // R1
         ocsel_r <= mode_r[OC_SELECT_BIT]; // R3
         bw_r    <= mode_r[BUS_WIDTH_BIT]; // R4
         dma_request_output_r  <= mode_r[DMA_REQUEST_POLARITY_BIT] ? dma_request_internal : !dma_request_internal; // R6
         ack_r   <= mode_r[DMA_ACK_POLARITY_BIT] ? ack_sync_r : !ack_sync_r; // R5
         // Analog sensing is outside this block; only the digital path is qualified here
         ocf_r   <= mode_r[OC_SELECT_BIT] ? 3'h0 : ~oc_sync_r; // R3
      end
   end

   assign transceiver_reset_all    = xrst_r;
   assign overcurrent_sense_select = ocsel_r;
   assign bus_width_32             = bw_r;
   assign dma_request_output       = dma_request_output_r;
   assign dma_ack_active           = ack_r;
   assign overcurrent_flag         = ocf_r;

   // Master enable gates every masked pending event
   assign irq_request = mode_r[IRQ_MASTER_BIT] && |(status_r & mask_r); // R8 R9

   irq_pulse_shaper #(
      .WIDTH       (PULSE_WIDTH)
   ) u_shaper (
      .clock       (clock),
      .srst        (srst),
      .request     (irq_request),
      .edge_mode   (mode_r[IRQ_TRIG_BIT]),
      .active_high (mode_r[IRQ_POL_BIT]),
      .irq_pin_r   (irq_out)
   ); // R7 R10

   // Register writes land at the edge that ends the data phase
   sequence write_mode_s;
      wr_pend_r && addr_r == HW_MODE_OFFSET;
   endsequence
   AST_MODE_WRITE: assert property (@(posedge clock) disable iff (srst) // R2
      write_mode_s |=> (mode_r == ($past(hwdata) & HW_MODE_WMASK)))
      else $error("mode write not stored");
   AST_MODE_READ: assert property (@(posedge clock) disable iff (srst) // R2
      (addr_phase && !hwrite && haddr == HW_MODE_OFFSET) |=> (hrdata == $past(mode_r)))
      else $error("mode read data wrong");
   AST_MASK_WRITE: assert property (@(posedge clock) disable iff (srst) // R9
      (wr_pend_r && addr_r == IRQ_MASK_OFFSET) |=> (mask_r == $past(hwdata[3:0])))
      else $error("mask write not stored");

   // Transceiver reset follows bit 31 both ways
   AST_XRST_FOLLOW: assert property (@(posedge clock) disable iff (srst) // R1
      mode_r[XCVR_RESET_BIT] ##1 mode_r[XCVR_RESET_BIT] |=> transceiver_reset_all)
      else $error("transceiver reset not held");
   AST_XRST_RELEASE: assert property (@(posedge clock) disable iff (srst) // R1
      !mode_r[XCVR_RESET_BIT] |=> !transceiver_reset_all)
      else $error("transceiver reset not released");

   // Overcurrent select and the digital flag path
   AST_OC_SEL: assert property (@(posedge clock) disable iff (srst) // R3
      ##1 overcurrent_sense_select == $past(mode_r[OC_SELECT_BIT]))
      else $error("overcurrent select mismatch");
   AST_OC_FLAGS: assert property (@(posedge clock) disable iff (srst) // R3
      1'b1 |=> (overcurrent_flag == ($past(mode_r[OC_SELECT_BIT]) ? 3'h0 : ~$past(oc_sync_r))))
      else $error("overcurrent flags wrong");
   AST_BUS_WIDTH: assert property (@(posedge clock) $fell(srst) |-> bus_width_32) // R4
      else $error("bus width not 32 after reset");

   // DMA handshake polarity, both settings of each bit
   AST_DMA_ACK_POLARITY: assert property (@(posedge clock) disable iff (srst) // R5
      (mode_r[DMA_ACK_POLARITY_BIT] && $stable(mode_r)) |=> dma_ack_active == $past(ack_sync_r))
      else $error("ack polarity wrong");
   AST_DMA_ACK_INPUT_LOW: assert property (@(posedge clock) disable iff (srst) // R5
      !mode_r[DMA_ACK_POLARITY_BIT] |=> (dma_ack_active == !$past(ack_sync_r)))
      else $error("active low ack not inverted");
   AST_DMA_REQUEST_POLARITY: assert property (@(posedge clock) disable iff (srst) // R6
      $stable(mode_r) |=> dma_request_output == ($past(mode_r[DMA_REQUEST_POLARITY_BIT]) ~^ $past(dma_request_internal)))
      else $error("request polarity wrong");

   // Master enable off keeps the pin at its inactive level for either polarity
   AST_IRQ_OFF: assert property (@(posedge clock) disable iff (srst) // R8
      (!mode_r[IRQ_MASTER_BIT] && mode_r[IRQ_POL_BIT])[*2] |=> !irq_out)
      else $error("interrupt while disabled");
   AST_IRQ_GATED: assert property (@(posedge clock) disable iff (srst) // R8
      !mode_r[IRQ_MASTER_BIT] |=> (irq_out == !$past(mode_r[IRQ_POL_BIT])))
      else $error("interrupt asserted with master enable off");

   // Level mode: the pin tracks the gated request one cycle later
   AST_IRQ_LEVEL: assert property (@(posedge clock) disable iff (srst) // R7 R9
      (irq_request && !mode_r[IRQ_TRIG_BIT] && mode_r[IRQ_POL_BIT]) |=> irq_out)
      else $error("level interrupt missing");
   AST_LEVEL_FOLLOW: assert property (@(posedge clock) disable iff (srst) // R7 R9
      !mode_r[IRQ_TRIG_BIT] |=> (irq_out == ($past(irq_request) ~^ $past(mode_r[IRQ_POL_BIT]))))
      else $error("level interrupt does not follow request");

   // Edge mode: a fresh request starts the pulse at the active level
   sequence request_rise_s;
      !irq_request ##1 (irq_request && mode_r[IRQ_TRIG_BIT] && $stable(mode_r));
   endsequence
   AST_EDGE_START: assert property (@(posedge clock) disable iff (srst) // R7 R10
      request_rise_s |=> (irq_out == $past(mode_r[IRQ_POL_BIT])))
      else $error("edge pulse did not start at active level");

   // Sticky status: events set, ones written clear, set wins a tie
   AST_STATUS_SET: assert property (@(posedge clock) disable iff (srst) // R9
      (|event_in) |=> ((status_r & $past(event_in)) == $past(event_in)))
      else $error("event not captured in status");
   AST_STATUS_CLEAR: assert property (@(posedge clock) disable iff (srst) // R9
      (wr_pend_r && addr_r == IRQ_STATUS_OFFSET && event_in == 4'h0) |=> ((status_r & $past(hwdata[3:0])) == 4'h0))
      else $error("status bits not cleared");
endmodule

// file: host_bus_master.sv
// AHB-Lite master model standing in for the host processor.
// Assumes a single slave whose hreadyout is fed back as hready.
module host_bus_master
   import mode_ctrl_pkg::*;
(
   // Clock
   input  wire logic        clock,
   // Master side of the bus
   output logic             hsel,
   output logic      [11:0] haddr,
   output logic      [1:0]  htrans,
   output logic             hwrite,
   output logic      [2:0]  hsize,
   output logic      [31:0] hwdata,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata
);
   // Bus idle from time zero, word transfers only
   initial begin
      hsel = 1'b0;
      haddr = 12'h000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
   end

   // One single transfer; waits on hready at rising edges, never on a fixed count
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clock);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      // Address phase stands until hready is seen high at a rising edge
      @(posedge clock);
      while (hready !== 1'b1) begin
         @(posedge clock);
      end
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wr ? wd : ~hwdata; // Reads leave no stale data behind
      // Data phase ends at the edge where hready is high; read data taken there
      @(posedge clock);
      while (hready !== 1'b1) begin
         @(posedge clock);
      end
      rd = hrdata;
      haddr <= ~a;
   endtask
endmodule

// file: hardware_mode_control_register_tb_top.sv
// Self-checking bench for the mode control register.
// Assumes the host model drives the bus; pins and events come from here.
module hardware_mode_control_register_tb_top;
   import mode_ctrl_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PW = 4; // Short pulse keeps the edge test quick
   logic        clock, srst, hsel, hwrite, hreadyout, dma_request_output_in, dma_ack_input_in, p1_n, p2_n, p3_n;
   logic        xr, ocs, bw32, dma_request_output_out, dma_ack_input_act, irq_out;
   logic [11:0] haddr;
   logic [1:0]  htrans, hresp;
   logic [2:0]  hsize, oc_flag;
   logic [31:0] hwdata, hrdata, mode_m, d;
   logic [3:0]  event_in, status_m;
   int          fail_count, total_checks, n;

   host_bus_master u_host (.clock(clock), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));
   hardware_mode_control_register #(.PULSE_WIDTH(PW)) u_hardware_mode_control_register (.clock(clock), .srst(srst),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
      .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .event_in(event_in),
      .dma_request_internal(dma_request_output_in), .dma_ack_input(dma_ack_input_in), .overcurrent_input_port1_n(p1_n),
      .overcurrent_input_port2_n(p2_n), .overcurrent_input_port3_n(p3_n), .transceiver_reset_all(xr),
      .overcurrent_sense_select(ocs), .bus_width_32(bw32), .dma_request_output(dma_request_output_out),
      .dma_ack_active(dma_ack_input_act), .overcurrent_flag(oc_flag), .irq_out(irq_out));

   // Free-running clock, 8 ns period
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      logic [31:0] unused;
      u_host.xfer(1'b1, a, v, unused);
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
      logic [31:0] got;
      u_host.xfer(1'b0, a, 32'h0000_0000, got);
      check(got, exp, what);
   endtask

   task automatic pulse_event(input logic [3:0] v);
      @(posedge clock);
      event_in <= v;
      @(posedge clock);
      event_in <= 4'h0;
      status_m = status_m | v;
   endtask

   task automatic settle(input int c);
      repeat (c) @(posedge clock);
      @(negedge clock);
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Watchdog: whole sequence needs well under 5000 cycles
   initial begin
      #100000;
      fail_count++;
      complete_run();
   end

   // Main sequence
   initial begin
      {srst, dma_request_output_in, dma_ack_input_in, p1_n, p2_n, p3_n, event_in} = {6'b100111, 4'h0};
      fail_count = 0;
      total_checks = 0;
      status_m = 4'h0;
      mode_m = HW_MODE_RESET;
      void'($urandom(91094));
      repeat (2) @(posedge clock);
      srst <= 1'b0;
      settle(1);
      check({31'h0, bw32}, 32'h1, "bus width after reset");
      check({31'h0, irq_out}, 32'h1, "irq idle after reset");
      rd_chk(HW_MODE_OFFSET, HW_MODE_RESET, "mode reset value");
      check({30'h0, hresp}, {30'h0, HRESP_OKAY}, "response code");
      rd_chk(12'h304, 32'h0000_0000, "unmapped read");
      $display("test reset done");
      // Mode fields against pins; all writable bits but 2..0 set, all clear, then random
      for (int i = 0; i < 8; i++) begin
         d = (i == 0) ? HW_MODE_WMASK : (i == 1) ? 32'h0 : $urandom;
         mode_m = d & HW_MODE_WMASK & ~32'h7;
         wr(HW_MODE_OFFSET, mode_m);
         {dma_request_output_in, dma_ack_input_in, p3_n, p2_n, p1_n} <= 5'($urandom);
         settle(5);
         rd_chk(HW_MODE_OFFSET, mode_m, "mode readback");
         check({31'h0, xr}, {31'h0, mode_m[31]}, "transceiver reset");
         check({31'h0, ocs}, {31'h0, mode_m[15]}, "overcurrent select");
         check({29'h0, oc_flag}, mode_m[15] ? 32'h0 : {29'h0, ~p3_n, ~p2_n, ~p1_n}, "overcurrent flags");
         check({31'h0, bw32}, {31'h0, mode_m[8]}, "bus width");
         check({31'h0, dma_ack_input_act}, {31'h0, dma_ack_input_in ~^ mode_m[6]}, "dma ack polarity");
         check({31'h0, dma_request_output_out}, {31'h0, dma_request_output_in ~^ mode_m[5]}, "dma request polarity");
      end
      wr(HW_MODE_OFFSET, 32'h0000_0000);
      settle(3);
      check({31'h0, xr}, 32'h0, "transceiver reset released");
      $display("test mode fields done");
      // Interrupt gating, masking, clearing and pulse shape per polarity
      for (int pol = 0; pol < 2; pol++) begin
         wr(IRQ_MASK_OFFSET, 32'h0000_000F);
         wr(HW_MODE_OFFSET, 32'(pol) << 2);
         pulse_event(4'h5);
         settle(4);
         check({31'h0, irq_out}, {31'h0, ~pol[0]}, "irq with master off");
         rd_chk(IRQ_STATUS_OFFSET, {28'h0, status_m}, "status sticky");
         wr(HW_MODE_OFFSET, (32'(pol) << 2) | 32'h1);
         settle(3);
         check({31'h0, irq_out}, {31'h0, pol[0]}, "irq level active");
         wr(IRQ_MASK_OFFSET, 32'h0000_0000);
         settle(3);
         check({31'h0, irq_out}, {31'h0, ~pol[0]}, "irq masked");
         wr(IRQ_MASK_OFFSET, 32'h0000_000F);
         wr(IRQ_STATUS_OFFSET, {28'h0, status_m});
         status_m = 4'h0;
         settle(3);
         check({31'h0, irq_out}, {31'h0, ~pol[0]}, "irq after clear");
         rd_chk(IRQ_STATUS_OFFSET, 32'h0, "status cleared");
         wr(HW_MODE_OFFSET, (32'(pol) << 2) | 32'h3);
         pulse_event(4'h8);
         n = 0;
         repeat (24) begin
            @(negedge clock);
            if (irq_out === pol[0]) n++;
         end
         check(32'(n), 32'(PW), "edge pulse width");
         wr(IRQ_STATUS_OFFSET, 32'h0000_0008);
         status_m = 4'h0;
      end
      // Raw event view while an event is held, then the status it left behind
      event_in <= 4'h2;
      rd_chk(EVENT_OFFSET, 32'h0000_0002, "raw event view");
      event_in <= 4'h0;
      status_m = status_m | 4'h2;
      rd_chk(IRQ_STATUS_OFFSET, {28'h0, status_m}, "status from held event");
      $display("test interrupts done");
      complete_run();
   end
endmodule
